// File: inc/sdh_pkg.sv
// Constants, field layout and carrier types of the slot freeze and identity registers
package sdh_pkg;

  localparam int ADDR_W = 15;
  localparam int DATA_W = 16;

  // Register addresses on the host register port
  localparam logic [14:0] ID_ADDR     = 15'h0008;
  localparam logic [14:0] FREEZE_ADDR = 15'h002e;

  // Identity fields
  localparam int REV_LSB  = 8;
  localparam int CODE_LSB = 0;
  // Arbitrary values; real parts carry their own
  localparam logic [7:0] MASK_REV_DEF    = 8'h5a;
  localparam logic [7:0] DEVICE_CODE_DEF = 8'h3c;

  // Freeze register: one bit per slot E through L
  localparam int E_BIT = 4;
  localparam int F_BIT = 5;
  localparam int G_BIT = 6;
  localparam int H_BIT = 7;
  localparam int I_BIT = 8;
  localparam int J_BIT = 9;
  localparam int K_BIT = 10;
  localparam int L_BIT = 11;
  localparam int RSV_LSB = 12;
  localparam int RSV_MSB = 15;
  localparam logic [15:0] FREEZE_RESET = 16'h0000;
  localparam logic [15:0] FREEZE_MASK  = 16'h0ff0;
  localparam logic [15:0] READ_ZERO    = 16'h0000;
  localparam logic [3:0]  RSV_ZERO     = 4'h0;

  // Slot numbering: A is 0, L is 11; freeze bit index equals slot number
  localparam int          SLOT_W     = 4;
  localparam logic [3:0]  SLOT_FIRST = 4'h4;
  localparam logic [3:0]  SLOT_LAST  = 4'hb;
  localparam int          MEM_AW     = 3;
  localparam int          MEM_DEPTH  = 8;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } sdh_reg_req_t;

  typedef struct packed {
    logic              valid;
    logic [SLOT_W-1:0] slot;
    logic [DATA_W-1:0] data;
  } sdh_result_t;

  typedef struct packed {
    logic              valid;
    logic [MEM_AW-1:0] index;
  } sdh_slot_rd_t;

endpackage : sdh_pkg

// File: core/sdh_freeze_bank.sv
// Bank of per-slot freeze flip-flops, slots E through L
`timescale 1ns/1ps
module sdh_freeze_bank (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        wr_en,
  input  wire logic [15:0] wdata,
  output logic      [15:0] freeze_reg
);

  genvar gi;
  generate
    for (gi = 0; gi < sdh_pkg::DATA_W; gi++) begin : g_bit
      if (gi >= sdh_pkg::E_BIT && gi <= sdh_pkg::L_BIT) begin : g_rw
        always_ff @(posedge mclk or negedge rst_n) begin
          if (!rst_n) begin
            freeze_reg[gi] <= sdh_pkg::FREEZE_RESET[gi];
          end else if (wr_en) begin
            freeze_reg[gi] <= wdata[gi];
          end
        end
      end else begin : g_zero
        // Reserved and out-of-slice bits: a flop pinned at zero, so every bit is registered
        always_ff @(posedge mclk or negedge rst_n) begin
          if (!rst_n) begin
            freeze_reg[gi] <= sdh_pkg::FREEZE_RESET[gi];
          end else begin
            freeze_reg[gi] <= sdh_pkg::FREEZE_RESET[gi];
          end
        end
      end
    end
  endgenerate

endmodule : sdh_freeze_bank

// File: core/sdh_slot_mem.sv
// Data store for slots E through L with registered read data
`timescale 1ns/1ps
module sdh_slot_mem (
  input  wire logic                      mclk,
  input  wire logic                      rst_n,
  input  wire logic                      we,
  input  wire logic [sdh_pkg::MEM_AW-1:0] waddr,
  input  wire logic [sdh_pkg::DATA_W-1:0] wdata,
  input  wire logic                      re,
  input  wire logic [sdh_pkg::MEM_AW-1:0] raddr,
  output logic      [sdh_pkg::DATA_W-1:0] rdata_reg,
  output logic                           rvalid_reg
);

  logic [sdh_pkg::DATA_W-1:0] mem [sdh_pkg::MEM_DEPTH];

  // No reset on the array so it can map onto a small RAM
  always_ff @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg  <= sdh_pkg::READ_ZERO;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= re;
      if (re) begin
        rdata_reg <= mem[raddr];
      end
    end
  end

endmodule : sdh_slot_mem

// File: core/sdh_regs.sv
// Slot freeze and identity registers with the freeze-gated slot data store
//
// Summary of operation
// - A clear freeze bit lets new results update its slot's data, a set one keeps them unchanged.
// - Bit 11 of the freeze register is read/write, freezes slot L data and resets to zero.
// - Bit 10 of the freeze register is read/write, freezes slot K data and resets to zero.
// - Bit 9 of the freeze register is read/write, freezes slot J data and resets to zero.
// - Bit 8 of the freeze register is read/write, freezes slot I data and resets to zero.
// - Bit 7 of the freeze register is read/write, freezes slot H data and resets to zero.
// - Bit 6 of the freeze register is read/write, freezes slot G data and resets to zero.
// - Bit 5 of the freeze register is read/write, freezes slot F data and resets to zero.
// - Bit 4 of the freeze register is read/write, freezes slot E data and resets to zero.
`timescale 1ns/1ps
module sdh_regs #(
  parameter logic [7:0] MASK_REV    = sdh_pkg::MASK_REV_DEF,
  parameter logic [7:0] DEVICE_CODE = sdh_pkg::DEVICE_CODE_DEF
) (
  input  wire logic                         mclk,
  input  wire logic                         rst_n,
  input  wire sdh_pkg::sdh_reg_req_t        reg_req,
  output logic      [sdh_pkg::DATA_W-1:0]   rd_data_reg,
  output logic                              rd_valid_reg,
  input  wire sdh_pkg::sdh_result_t         result,
  input  wire sdh_pkg::sdh_slot_rd_t        slot_rd,
  output logic      [sdh_pkg::DATA_W-1:0]   slot_data_reg,
  output logic                              slot_valid_reg,
  output logic      [sdh_pkg::DATA_W-1:0]   freeze_reg
);

  // Address decode
  wire hit_id     = (reg_req.addr == sdh_pkg::ID_ADDR);
  wire hit_freeze = (reg_req.addr == sdh_pkg::FREEZE_ADDR);
  // Identity has no write path at all
  wire freeze_wr  = reg_req.wr && hit_freeze;

  wire [sdh_pkg::DATA_W-1:0] id_word = {MASK_REV, DEVICE_CODE};

  wire [sdh_pkg::DATA_W-1:0] rd_mux =
    hit_id     ? id_word :
    hit_freeze ? (freeze_reg & sdh_pkg::FREEZE_MASK) :
                 sdh_pkg::READ_ZERO;

  sdh_freeze_bank u_freeze (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .wr_en      (freeze_wr),
    .wdata      (reg_req.wdata & sdh_pkg::FREEZE_MASK),
    .freeze_reg (freeze_reg)
  );

  // Read answer one cycle after the request; unmapped reads give zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_reg  <= sdh_pkg::READ_ZERO;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_valid_reg <= reg_req.rd;
      if (reg_req.rd) begin
        rd_data_reg <= rd_mux;
      end
    end
  end

  // Results for slots outside E..L belong to other storage and are dropped here
  wire in_slice = (result.slot >= sdh_pkg::SLOT_FIRST) && (result.slot <= sdh_pkg::SLOT_LAST);
  wire slot_frozen = freeze_reg[result.slot];
  wire mem_we = result.valid && in_slice && !slot_frozen;
  wire [sdh_pkg::SLOT_W-1:0] slot_off = result.slot - sdh_pkg::SLOT_FIRST;
  wire [sdh_pkg::MEM_AW-1:0] mem_waddr = slot_off[sdh_pkg::MEM_AW-1:0];

  sdh_slot_mem u_mem (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .we         (mem_we),
    .waddr      (mem_waddr),
    .wdata      (result.data),
    .re         (slot_rd.valid),
    .raddr      (slot_rd.index),
    .rdata_reg  (slot_data_reg),
    .rvalid_reg (slot_valid_reg)
  );

  // Assertions

  frozen_no_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (result.valid && in_slice && freeze_reg[result.slot]) |-> !mem_we)
    else $error("Result written into a frozen slot");

  open_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (result.valid && in_slice && !freeze_reg[result.slot]) |-> mem_we)
    else $error("Result dropped for an open slot");

  freeze_l_a: assert property (@(posedge mclk) disable iff (!rst_n)
    freeze_wr |=> freeze_reg[sdh_pkg::L_BIT] == $past(reg_req.wdata[sdh_pkg::L_BIT]))
    else $error("Slot L freeze bit did not take the write");

  freeze_k_a: assert property (@(posedge mclk) disable iff (!rst_n)
    freeze_wr |=> freeze_reg[sdh_pkg::K_BIT] == $past(reg_req.wdata[sdh_pkg::K_BIT]))
    else $error("Slot K freeze bit did not take the write");

  freeze_j_a: assert property (@(posedge mclk) disable iff (!rst_n)
    freeze_wr |=> freeze_reg[sdh_pkg::J_BIT] == $past(reg_req.wdata[sdh_pkg::J_BIT]))
    else $error("Slot J freeze bit did not take the write");

  freeze_i_a: assert property (@(posedge mclk) disable iff (!rst_n)
    freeze_wr |=> freeze_reg[sdh_pkg::I_BIT] == $past(reg_req.wdata[sdh_pkg::I_BIT]))
    else $error("Slot I freeze bit did not take the write");

  freeze_h_a: assert property (@(posedge mclk) disable iff (!rst_n)
    freeze_wr |=> freeze_reg[sdh_pkg::H_BIT] == $past(reg_req.wdata[sdh_pkg::H_BIT]))
    else $error("Slot H freeze bit did not take the write");

  freeze_g_a: assert property (@(posedge mclk) disable iff (!rst_n)
    freeze_wr |=> freeze_reg[sdh_pkg::G_BIT] == $past(reg_req.wdata[sdh_pkg::G_BIT]))
    else $error("Slot G freeze bit did not take the write");

  freeze_f_a: assert property (@(posedge mclk) disable iff (!rst_n)
    freeze_wr |=> freeze_reg[sdh_pkg::F_BIT] == $past(reg_req.wdata[sdh_pkg::F_BIT]))
    else $error("Slot F freeze bit did not take the write");

  freeze_e_a: assert property (@(posedge mclk) disable iff (!rst_n)
    freeze_wr |=> freeze_reg[sdh_pkg::E_BIT] == $past(reg_req.wdata[sdh_pkg::E_BIT]))
    else $error("Slot E freeze bit did not take the write");

  freeze_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !freeze_wr |=> $stable(freeze_reg))
    else $error("Freeze register changed without a write");

  id_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (reg_req.rd && hit_id) |=> rd_valid_reg && rd_data_reg == {MASK_REV, DEVICE_CODE})
    else $error("Identity read returned a wrong value");

  rsv_zero_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (reg_req.rd && hit_freeze) |=>
      rd_valid_reg && rd_data_reg[sdh_pkg::RSV_MSB:sdh_pkg::RSV_LSB] == sdh_pkg::RSV_ZERO)
    else $error("Reserved freeze bits read non-zero");

  // Register port answers

  rd_valid_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_req.rd |=> rd_valid_reg)
    else $error("Read taken without a valid pulse");

  rd_valid_clr_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !reg_req.rd |=> !rd_valid_reg)
    else $error("Valid pulse without a read");

  wr_no_answer_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (reg_req.wr && !reg_req.rd) |=> !rd_valid_reg)
    else $error("Write alone gave a read answer");

  rd_data_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !reg_req.rd |=> $stable(rd_data_reg))
    else $error("Read data changed without a read");

  unmapped_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (reg_req.rd && !hit_id && !hit_freeze) |=> rd_data_reg == sdh_pkg::READ_ZERO)
    else $error("Unmapped read returned non-zero data");

  id_fields_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (reg_req.rd && hit_id) |=>
      rd_data_reg[sdh_pkg::REV_LSB +: $bits(MASK_REV)] == MASK_REV &&
      rd_data_reg[sdh_pkg::CODE_LSB +: $bits(DEVICE_CODE)] == DEVICE_CODE)
    else $error("Identity fields not at their bit positions");

  freeze_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (reg_req.rd && hit_freeze) |=> rd_data_reg == $past(freeze_reg))
    else $error("Freeze read did not return the word held before the access");

  // Freeze register contents

  freeze_word_a: assert property (@(posedge mclk) disable iff (!rst_n)
    freeze_wr |=> freeze_reg == ($past(reg_req.wdata) & sdh_pkg::FREEZE_MASK))
    else $error("Freeze register did not take the masked write word");

  id_wr_ignored_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (reg_req.wr && hit_id) |=> $stable(freeze_reg))
    else $error("Identity write disturbed the freeze register");

  other_wr_ignored_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (reg_req.wr && !hit_freeze) |=> $stable(freeze_reg))
    else $error("Write to another address disturbed the freeze register");

  rsv_const_a: assert property (@(posedge mclk) disable iff (!rst_n)
    freeze_reg[sdh_pkg::RSV_MSB:sdh_pkg::RSV_LSB] == sdh_pkg::RSV_ZERO)
    else $error("Reserved freeze bits hold non-zero");

  unused_zero_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (freeze_reg & ~sdh_pkg::FREEZE_MASK) == sdh_pkg::READ_ZERO)
    else $error("Freeze bits outside slots E to L hold non-zero");

  // Reset values, watched while reset is low, hence no disable here

  reset_freeze_a: assert property (@(posedge mclk)
    !rst_n |-> freeze_reg == sdh_pkg::FREEZE_RESET)
    else $error("Freeze register not at its reset value");

  reset_answer_a: assert property (@(posedge mclk)
    !rst_n |-> !rd_valid_reg && !slot_valid_reg && rd_data_reg == sdh_pkg::READ_ZERO)
    else $error("Read answer outputs not cleared by reset");

  reset_slot_a: assert property (@(posedge mclk)
    !rst_n |-> slot_data_reg == sdh_pkg::READ_ZERO)
    else $error("Slot data output not cleared by reset");

  // Slot data port

  slot_valid_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
    slot_rd.valid |=> slot_valid_reg)
    else $error("Slot read taken without a valid pulse");

  slot_valid_clr_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !slot_rd.valid |=> !slot_valid_reg)
    else $error("Slot valid pulse without a slot read");

  slot_data_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !slot_rd.valid |=> $stable(slot_data_reg))
    else $error("Slot data changed without a slot read");

  outside_drop_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (result.valid && (result.slot < sdh_pkg::SLOT_FIRST || result.slot > sdh_pkg::SLOT_LAST))
      |-> !mem_we)
    else $error("Result of a slot outside E to L reached the store");

  // Per-slot decode written out, so a wrong slot-to-word mapping shows

  slot_e_open_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (result.valid && result.slot == 4'(sdh_pkg::E_BIT) && !freeze_reg[sdh_pkg::E_BIT])
      |-> mem_we && mem_waddr == 3'(sdh_pkg::E_BIT - sdh_pkg::E_BIT))
    else $error("Slot E result not stored in its own word");

  slot_e_held_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (result.valid && result.slot == 4'(sdh_pkg::E_BIT) && freeze_reg[sdh_pkg::E_BIT])
      |-> !mem_we)
    else $error("Slot E result stored while the slot is frozen");

  slot_f_open_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (result.valid && result.slot == 4'(sdh_pkg::F_BIT) && !freeze_reg[sdh_pkg::F_BIT])
      |-> mem_we && mem_waddr == 3'(sdh_pkg::F_BIT - sdh_pkg::E_BIT))
    else $error("Slot F result not stored in its own word");

  slot_f_held_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (result.valid && result.slot == 4'(sdh_pkg::F_BIT) && freeze_reg[sdh_pkg::F_BIT])
      |-> !mem_we)
    else $error("Slot F result stored while the slot is frozen");

  slot_g_open_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (result.valid && result.slot == 4'(sdh_pkg::G_BIT) && !freeze_reg[sdh_pkg::G_BIT])
      |-> mem_we && mem_waddr == 3'(sdh_pkg::G_BIT - sdh_pkg::E_BIT))
    else $error("Slot G result not stored in its own word");

  slot_g_held_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (result.valid && result.slot == 4'(sdh_pkg::G_BIT) && freeze_reg[sdh_pkg::G_BIT])
      |-> !mem_we)
    else $error("Slot G result stored while the slot is frozen");

  slot_h_open_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (result.valid && result.slot == 4'(sdh_pkg::H_BIT) && !freeze_reg[sdh_pkg::H_BIT])
      |-> mem_we && mem_waddr == 3'(sdh_pkg::H_BIT - sdh_pkg::E_BIT))
    else $error("Slot H result not stored in its own word");

  slot_h_held_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (result.valid && result.slot == 4'(sdh_pkg::H_BIT) && freeze_reg[sdh_pkg::H_BIT])
      |-> !mem_we)
    else $error("Slot H result stored while the slot is frozen");

  slot_i_open_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (result.valid && result.slot == 4'(sdh_pkg::I_BIT) && !freeze_reg[sdh_pkg::I_BIT])
      |-> mem_we && mem_waddr == 3'(sdh_pkg::I_BIT - sdh_pkg::E_BIT))
    else $error("Slot I result not stored in its own word");

  slot_i_held_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (result.valid && result.slot == 4'(sdh_pkg::I_BIT) && freeze_reg[sdh_pkg::I_BIT])
      |-> !mem_we)
    else $error("Slot I result stored while the slot is frozen");

  slot_j_open_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (result.valid && result.slot == 4'(sdh_pkg::J_BIT) && !freeze_reg[sdh_pkg::J_BIT])
      |-> mem_we && mem_waddr == 3'(sdh_pkg::J_BIT - sdh_pkg::E_BIT))
    else $error("Slot J result not stored in its own word");

  slot_j_held_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (result.valid && result.slot == 4'(sdh_pkg::J_BIT) && freeze_reg[sdh_pkg::J_BIT])
      |-> !mem_we)
    else $error("Slot J result stored while the slot is frozen");

  slot_k_open_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (result.valid && result.slot == 4'(sdh_pkg::K_BIT) && !freeze_reg[sdh_pkg::K_BIT])
      |-> mem_we && mem_waddr == 3'(sdh_pkg::K_BIT - sdh_pkg::E_BIT))
    else $error("Slot K result not stored in its own word");

  slot_k_held_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (result.valid && result.slot == 4'(sdh_pkg::K_BIT) && freeze_reg[sdh_pkg::K_BIT])
      |-> !mem_we)
    else $error("Slot K result stored while the slot is frozen");

  slot_l_open_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (result.valid && result.slot == 4'(sdh_pkg::L_BIT) && !freeze_reg[sdh_pkg::L_BIT])
      |-> mem_we && mem_waddr == 3'(sdh_pkg::L_BIT - sdh_pkg::E_BIT))
    else $error("Slot L result not stored in its own word");

  slot_l_held_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (result.valid && result.slot == 4'(sdh_pkg::L_BIT) && freeze_reg[sdh_pkg::L_BIT])
      |-> !mem_we)
    else $error("Slot L result stored while the slot is frozen");

endmodule : sdh_regs

// File: testbench/slot_data_hold_and_id_regs_test.sv
// Self-checking bench of the slot freeze and identity registers
`timescale 1ns/1ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin fail_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module slot_data_hold_and_id_regs_test;
  // Arbitrary identity values, unlike the defaults, so a hardwired answer shows
  localparam logic [7:0]  REV  = 8'h69;
  localparam logic [7:0]  CODE = 8'h17;
  localparam logic [15:0] HELD = 16'h0aa0;
  logic                  mclk;
  logic                  rst_n;
  sdh_pkg::sdh_reg_req_t reg_req;
  sdh_pkg::sdh_result_t  result;
  sdh_pkg::sdh_slot_rd_t slot_rd;
  logic [15:0]           rd_data;
  logic [15:0]           slot_data;
  logic [15:0]           freeze;
  logic [15:0]           got;
  logic                  rd_valid;
  logic                  slot_valid;
  int                    fail_count = 0;
  int                    tests_run = 0;

  sdh_regs #(.MASK_REV(REV), .DEVICE_CODE(CODE)) u_dut (
    .mclk           (mclk),
    .rst_n          (rst_n),
    .reg_req        (reg_req),
    .rd_data_reg    (rd_data),
    .rd_valid_reg   (rd_valid),
    .result         (result),
    .slot_rd        (slot_rd),
    .slot_data_reg  (slot_data),
    .slot_valid_reg (slot_valid),
    .freeze_reg     (freeze)
  );

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic access(input logic wr, input logic rd, input logic [14:0] addr,
                        input logic [15:0] wdata, output logic [15:0] rdata);
    @(posedge mclk);
    #1 reg_req = '{wr, rd, addr, wdata};
    @(posedge mclk);
    #1 reg_req = '0;
    rdata = rd_data;
    if (rd) `CHK(rd_valid, 1'b1)
  endtask : access

  task automatic put(input int slot, input logic [15:0] d);
    @(posedge mclk);
    #1 result = '{1'b1, 4'(slot), d};
    @(posedge mclk);
    #1 result = '0;
  endtask : put

  task automatic get(input int slot, output logic [15:0] d);
    @(posedge mclk);
    #1 slot_rd = '{1'b1, 3'(slot - 4)};
    @(posedge mclk);
    #1 slot_rd = '0;
    `CHK(slot_valid, 1'b1)
    d = slot_data;
  endtask : get

  task automatic test_done;
    $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done

  initial begin
    rst_n = 1'b0;
    reg_req = '0;
    result = '0;
    slot_rd = '0;
    repeat (3) @(posedge mclk);
    #1 rst_n = 1'b1;
    `CHK(freeze, 16'h0000)
    access(1'b0, 1'b1, sdh_pkg::ID_ADDR, 16'h0000, got);
    `CHK(got, {REV, CODE})
    access(1'b1, 1'b0, sdh_pkg::ID_ADDR, 16'hffff, got);
    access(1'b0, 1'b1, sdh_pkg::ID_ADDR, 16'h0000, got);
    `CHK(got, {REV, CODE})
    access(1'b0, 1'b1, 15'h0009, 16'h0000, got);
    `CHK(got, 16'h0000)
    $display("end of test: identity");
    for (int i = 4; i < 12; i++) begin
      access(1'b1, 1'b0, sdh_pkg::FREEZE_ADDR, 16'h0001 << i, got);
      `CHK(freeze, 16'h0001 << i)
      access(1'b0, 1'b1, sdh_pkg::FREEZE_ADDR, 16'h0000, got);
      `CHK(got, 16'h0001 << i)
    end
    access(1'b1, 1'b0, sdh_pkg::FREEZE_ADDR, 16'hffff, got);
    // Read and write together: the read sees the old word
    access(1'b1, 1'b1, sdh_pkg::FREEZE_ADDR, 16'hf00f, got);
    `CHK(got, 16'h0ff0)
    `CHK(freeze, 16'h0000)
    // A write one address above the freeze register must not land
    access(1'b1, 1'b0, sdh_pkg::FREEZE_ADDR + 15'h0001, 16'hffff, got);
    `CHK(freeze, 16'h0000)
    $display("end of test: freeze bits");
    for (int s = 4; s < 12; s++) put(s, 16'(16'h1000 + s));
    access(1'b1, 1'b0, sdh_pkg::FREEZE_ADDR, HELD, got);
    for (int s = 4; s < 12; s++) put(s, 16'(16'h2000 + s));
    for (int s = 4; s < 12; s++) begin
      get(s, got);
      `CHK(got, 16'((HELD[s] ? 16'h1000 : 16'h2000) + s))
    end
    access(1'b1, 1'b0, sdh_pkg::FREEZE_ADDR, 16'h0000, got);
    for (int s = 4; s < 12; s++) put(s, 16'(16'h3000 + s));
    // Slots outside E..L must not alias onto stored words
    put(3, 16'hdead);
    put(12, 16'hbeef);
    for (int s = 4; s < 12; s++) begin
      get(s, got);
      `CHK(got, 16'(16'h3000 + s))
    end
    $display("end of test: hold");
    access(1'b1, 1'b0, sdh_pkg::FREEZE_ADDR, 16'h0ff0, got);
    put(8, 16'h4008);
    @(posedge mclk);
    #1 rst_n = 1'b0;
    @(posedge mclk);
    #1;
    `CHK(freeze, 16'h0000)
    `CHK(rd_data, 16'h0000)
    `CHK(rd_valid, 1'b0)
    `CHK(slot_data, 16'h0000)
    `CHK(slot_valid, 1'b0)
    rst_n = 1'b1;
    // Store is not reset: slot I still holds its last open-slot word
    access(1'b1, 1'b0, sdh_pkg::FREEZE_ADDR, 16'h0100, got);
    access(1'b0, 1'b1, sdh_pkg::FREEZE_ADDR, 16'h0000, got);
    `CHK(got, 16'h0100)
    put(8, 16'h5008);
    get(8, got);
    `CHK(got, 16'h3008)
    $display("end of test: second reset");
    test_done();
  end

  // About 150 cycles expected; 2000 leaves ample margin
  initial begin
    #100000;
    fail_count++;
    test_done();
  end
endmodule : slot_data_hold_and_id_regs_test
